/* logic/adcpp_top.sv */
// Digital post-processing, offset loop and power modes of a dual-channel converter
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module adcpp_top #(
	parameter logic [14:0] SLEEP_WAKE = 15'(adcpp_pkg::SLEEP_WAKE_CYCLES),
	parameter logic [14:0] STANDBY_WAKE = 15'(adcpp_pkg::STANDBY_WAKE_CYCLES)
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [13:0] sample_a_i,
	input wire logic [13:0] sample_b_i,
	input wire logic power_mode_pin_1_i,
	input wire logic power_mode_pin_2_i,
	input wire logic power_mode_pin_3_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	output logic [13:0] channel_a_output_bus_o,
	output logic channel_a_output_oe_o,
	output logic [13:0] channel_b_output_bus_o,
	output logic channel_b_output_oe_o,
	output logic channel_a_valid_o,
	output logic channel_b_valid_o,
	output logic mux_carries_a_o
);
	localparam int ND = adcpp_pkg::LAT_DIG - 1;

	typedef struct packed {
		logic dig_en;
		logic off_en;
		logic off_hold;
		logic [3:0] gain;
		logic [3:0] tc;
		logic sleep_bit;
		logic stby_a;
		logic stby_b;
		logic mux_bit;
		logic use_pins;
		logic [ND-1:0][13:0] pipe_a;
		logic [ND-1:0][13:0] pipe_b;
		logic signed [46:0] acc_a;
		logic signed [46:0] acc_b;
		logic [13:0] out_a;
		logic [13:0] out_b;
		logic oe_a;
		logic oe_b;
		logic [14:0] wake_a;
		logic [14:0] wake_b;
		logic val_a;
		logic val_b;
		logic was_sleep;
		logic was_down_a;
		logic was_down_b;
		logic mux_phase;
		logic mux_flag;
		logic [31:0] rdata;
	} adcpp_state_s;

	adcpp_state_s st;
	adcpp_state_s next_st;

	// Gain in 0.5 dB steps, 12 fraction bits; codes above 12 are never stored
	localparam logic [0:15][13:0] GAIN_TAB = {
		14'h1000, 14'h10f3, 14'h11f4, 14'h1304, 14'h1425, 14'h1556, 14'h169a, 14'h17f1,
		14'h195c, 14'h1adc, 14'h1c74, 14'h1e23, 14'h1fed, 14'h1fed, 14'h1fed, 14'h1fed};

	// Analog full-scale in mVpp for each gain code
	localparam logic [0:15][11:0] FS_TAB = {
		12'h07d0, 12'h0760, 12'h06f4, 12'h0693, 12'h0636, 12'h05d8, 12'h058c, 12'h0536,
		12'h04ec, 12'h04a5, 12'h0460, 12'h0423, 12'h03e8, 12'h03e8, 12'h03e8, 12'h03e8};

	function automatic logic [13:0] sat14(input logic signed [31:0] v);
		if (v > 32'sd8191)
			sat14 = 14'h1fff;
		else if (v < -32'sd8192)
			sat14 = 14'h2000;
		else
			sat14 = v[13:0];
	endfunction

	function automatic logic signed [13:0] clamp_off(input logic signed [46:0] v);
		if (v > 47'(adcpp_pkg::OFFSET_LIMIT_LSB))
			clamp_off = 14'(adcpp_pkg::OFFSET_LIMIT_LSB);
		else if (v < -47'(adcpp_pkg::OFFSET_LIMIT_LSB))
			clamp_off = -14'(adcpp_pkg::OFFSET_LIMIT_LSB);
		else
			clamp_off = v[13:0];
	endfunction

	logic pin_bad;
	logic sleep_now;
	logic down_a;
	logic down_b;
	logic mux_now;
	logic [2:0] pins;
	logic [5:0] shift;
	logic signed [31:0] gained_a;
	logic signed [31:0] gained_b;
	logic signed [13:0] est_a;
	logic signed [13:0] est_b;
	logic [13:0] proc_a;
	logic [13:0] proc_b;
	logic [13:0] send_a;
	logic [13:0] send_b;

	always_comb begin
		pins = {power_mode_pin_3_i, power_mode_pin_2_i, power_mode_pin_1_i};
		pin_bad = 1'b0;
		sleep_now = st.sleep_bit;
		down_a = st.stby_a;
		down_b = st.stby_b;
		mux_now = st.mux_bit;
		if (st.use_pins) begin
			sleep_now = 1'b0;
			down_a = 1'b0;
			down_b = 1'b0;
			mux_now = 1'b0;
			case (pins)
				adcpp_pkg::PINS_NORMAL: pin_bad = 1'b0;
				adcpp_pkg::PINS_SLEEP: sleep_now = 1'b1;
				adcpp_pkg::PINS_A_DOWN: down_a = 1'b1;
				adcpp_pkg::PINS_MUX: mux_now = 1'b1;
				default: pin_bad = 1'b1; // Unsupported codes fall back to normal
			endcase
		end

		// Offset estimate is the accumulator scaled by the time constant
		shift = 6'(adcpp_pkg::TC_BASE_SHIFT) + {2'b00, st.tc};
		est_a = clamp_off(st.acc_a >>> shift);
		est_b = clamp_off(st.acc_b >>> shift);
		gained_a = (32'(signed'(st.pipe_a[ND-1])) * 32'(signed'({1'b0, GAIN_TAB[st.gain]})))
			>>> adcpp_pkg::GAIN_FRAC;
		gained_b = (32'(signed'(st.pipe_b[ND-1])) * 32'(signed'({1'b0, GAIN_TAB[st.gain]})))
			>>> adcpp_pkg::GAIN_FRAC;
		proc_a = sat14(gained_a);
		proc_b = sat14(gained_b);
		if (st.off_en) begin
			proc_a = sat14(32'(signed'(proc_a)) - 32'(est_a));
			proc_b = sat14(32'(signed'(proc_b)) - 32'(est_b));
		end
		// Raw path taps early, processed path late
		send_a = st.dig_en ? proc_a : st.pipe_a[adcpp_pkg::LAT_RAW - 2];
		send_b = st.dig_en ? proc_b : st.pipe_b[adcpp_pkg::LAT_RAW - 2];

		next_st = st;
		next_st.pipe_a[0] = sample_a_i;
		next_st.pipe_b[0] = sample_b_i;
		for (int i = 1; i < ND; i++) begin
			next_st.pipe_a[i] = st.pipe_a[i-1];
			next_st.pipe_b[i] = st.pipe_b[i-1];
		end

		if (!(st.dig_en && st.off_en)) begin
			next_st.acc_a = '0;
			next_st.acc_b = '0;
		end else if (st.off_hold) begin
			next_st.acc_a = st.acc_a + 47'(signed'(gained_a)) - 47'(est_a);
			next_st.acc_b = st.acc_b + 47'(signed'(gained_b)) - 47'(est_b);
		end

		// Power modes and wake-up timing
		next_st.was_sleep = sleep_now;
		next_st.was_down_a = down_a;
		next_st.was_down_b = down_b;
		if (sleep_now) begin
			next_st.wake_a = '0;
			next_st.wake_b = '0;
			next_st.val_a = 1'b0;
			next_st.val_b = 1'b0;
		end else begin
			if (st.was_sleep) begin
				next_st.wake_a = SLEEP_WAKE;
				next_st.wake_b = SLEEP_WAKE;
			end
			if (down_a) begin
				next_st.wake_a = '0;
				next_st.val_a = 1'b0;
			end else if (st.was_down_a && !st.was_sleep) begin
				next_st.wake_a = STANDBY_WAKE;
			end else if (st.wake_a != '0) begin
				next_st.wake_a = st.wake_a - 15'h0001;
			end
			if (down_b) begin
				next_st.wake_b = '0;
				next_st.val_b = 1'b0;
			end else if (st.was_down_b && !st.was_sleep) begin
				next_st.wake_b = STANDBY_WAKE;
			end else if (st.wake_b != '0) begin
				next_st.wake_b = st.wake_b - 15'h0001;
			end
			next_st.val_a = !down_a && !st.was_sleep && !(st.was_down_a && !st.was_sleep)
				&& (st.wake_a <= 15'h0001);
			next_st.val_b = !down_b && !st.was_sleep && !(st.was_down_b && !st.was_sleep)
				&& (st.wake_b <= 15'h0001);
		end

		// Mux mode alternates A and B on bus B; it halves each channel's rate
		next_st.mux_phase = mux_now ? !st.mux_phase : 1'b0;
		next_st.mux_flag = mux_now && !st.mux_phase;
		next_st.oe_a = !sleep_now && !mux_now;
		next_st.oe_b = !sleep_now;
		next_st.out_a = (sleep_now || mux_now || down_a) ? 14'h0000 : send_a;
		if (sleep_now)
			next_st.out_b = 14'h0000;
		else if (mux_now)
			next_st.out_b = st.mux_phase ? send_b : send_a;
		else
			next_st.out_b = down_b ? 14'h0000 : send_b;

		if (reg_wr_i) begin
			case (reg_addr_i)
				adcpp_pkg::REG_CONTROL: begin
					next_st.dig_en = reg_wdata_i[adcpp_pkg::CTL_DIG_EN];
					next_st.off_en = reg_wdata_i[adcpp_pkg::CTL_OFF_EN];
					next_st.off_hold = reg_wdata_i[adcpp_pkg::CTL_OFF_HOLD];
					next_st.gain = (reg_wdata_i[adcpp_pkg::CTL_GAIN_LO +: 4] > adcpp_pkg::GAIN_MAX_CODE)
						? adcpp_pkg::GAIN_MAX_CODE : reg_wdata_i[adcpp_pkg::CTL_GAIN_LO +: 4];
					// Reserved codes clamp to the longest defined constant
					next_st.tc = (reg_wdata_i[adcpp_pkg::CTL_TC_LO +: 4] > adcpp_pkg::TC_MAX_CODE)
						? adcpp_pkg::TC_MAX_CODE : reg_wdata_i[adcpp_pkg::CTL_TC_LO +: 4];
				end
				adcpp_pkg::REG_POWER: begin
					next_st.sleep_bit = reg_wdata_i[adcpp_pkg::PWR_SLEEP];
					next_st.stby_a = reg_wdata_i[adcpp_pkg::PWR_STBY_A];
					next_st.stby_b = reg_wdata_i[adcpp_pkg::PWR_STBY_B];
					next_st.mux_bit = reg_wdata_i[adcpp_pkg::PWR_MUX];
					next_st.use_pins = reg_wdata_i[adcpp_pkg::PWR_USE_PINS];
				end
				default: next_st.rdata = st.rdata;
			endcase
		end

		next_st.rdata = 32'h0000_0000;
		if (reg_rd_i) begin
			case (reg_addr_i)
				adcpp_pkg::REG_CONTROL: begin
					next_st.rdata[adcpp_pkg::CTL_DIG_EN] = st.dig_en;
					next_st.rdata[adcpp_pkg::CTL_OFF_EN] = st.off_en;
					next_st.rdata[adcpp_pkg::CTL_OFF_HOLD] = st.off_hold;
					next_st.rdata[adcpp_pkg::CTL_GAIN_LO +: 4] = st.gain;
					next_st.rdata[adcpp_pkg::CTL_TC_LO +: 4] = st.tc;
				end
				adcpp_pkg::REG_POWER: begin
					next_st.rdata[adcpp_pkg::PWR_SLEEP] = st.sleep_bit;
					next_st.rdata[adcpp_pkg::PWR_STBY_A] = st.stby_a;
					next_st.rdata[adcpp_pkg::PWR_STBY_B] = st.stby_b;
					next_st.rdata[adcpp_pkg::PWR_MUX] = st.mux_bit;
					next_st.rdata[adcpp_pkg::PWR_USE_PINS] = st.use_pins;
				end
				adcpp_pkg::REG_STATUS: begin
					next_st.rdata[adcpp_pkg::STS_SLEEP] = sleep_now;
					next_st.rdata[adcpp_pkg::STS_VALID_A] = st.val_a;
					next_st.rdata[adcpp_pkg::STS_VALID_B] = st.val_b;
					next_st.rdata[adcpp_pkg::STS_PIN_BAD] = pin_bad;
					next_st.rdata[adcpp_pkg::STS_FS_LO +: 12] = FS_TAB[st.gain];
				end
				adcpp_pkg::REG_OFFSET_A: next_st.rdata = 32'(est_a);
				adcpp_pkg::REG_OFFSET_B: next_st.rdata = 32'(est_b);
				default: next_st.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= '0;
			st.off_hold <= adcpp_pkg::CTL_OFF_HOLD_RST;
			st.oe_a <= 1'b1;
			st.oe_b <= 1'b1;
			st.val_a <= 1'b1;
			st.val_b <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign reg_rdata_o = st.rdata;
	assign channel_a_output_bus_o = st.out_a;
	assign channel_a_output_oe_o = st.oe_a;
	assign channel_b_output_bus_o = st.out_b;
	assign channel_b_output_oe_o = st.oe_b;
	assign channel_a_valid_o = st.val_a;
	assign channel_b_valid_o = st.val_b;
	assign mux_carries_a_o = st.mux_flag;

	// Helper: consecutive cycles with a fixed path configuration
	logic [5:0] raw_run;
	logic [5:0] dig_run;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			raw_run <= 6'h00;
			dig_run <= 6'h00;
		end else begin
			if (!st.dig_en && !sleep_now && !mux_now && !down_a)
				raw_run <= (raw_run == 6'h3f) ? raw_run : raw_run + 6'h01;
			else
				raw_run <= 6'h00;
			if (st.dig_en && !st.off_en && st.gain == 4'h0 && !sleep_now && !mux_now && !down_a)
				dig_run <= (dig_run == 6'h3f) ? dig_run : dig_run + 6'h01;
			else
				dig_run <= 6'h00;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_leave_sleep;
		$past(sleep_now) && !sleep_now;
	endsequence

	sequence s_stay_invalid;
		!channel_a_valid_o && !channel_b_valid_o;
	endsequence

	a_raw_latency: assert property (raw_run > 6'd17 |-> channel_a_output_bus_o == $past(sample_a_i, 16))
		else $error("raw path latency is not 16 cycles");
	a_dig_latency: assert property (dig_run > 6'd21 |-> channel_a_output_bus_o == $past(sample_a_i, 20))
		else $error("digital path latency wrong");
	a_gain_range: assert property (st.gain <= adcpp_pkg::GAIN_MAX_CODE && st.tc <= adcpp_pkg::TC_MAX_CODE)
		else $error("gain or time constant out of range");
	a_offset_clear: assert property (!st.off_en ##1 1 |-> st.acc_a == '0 && st.acc_b == '0)
		else $error("offset estimate kept while loop disabled");
	a_hold_freeze: assert property (st.off_hold == 1'b0 && st.off_en && st.dig_en |=> $stable(st.acc_a))
		else $error("estimate moved while held");
	a_offset_limit: assert property (est_a <= 14'sd81 && est_a >= -14'sd81)
		else $error("offset correction exceeds limit");
	a_sleep_tristate: assert property (sleep_now |=> !channel_a_output_oe_o && !channel_b_output_oe_o)
		else $error("pins driven during sleep");
	a_mux_a_off: assert property (mux_now && !sleep_now |=> !channel_a_output_oe_o && channel_b_output_oe_o)
		else $error("bus A driven in mux mode");
	a_wake_wait: assert property (s_leave_sleep |-> s_stay_invalid [*8])
		else $error("data valid too soon after sleep");
	a_pin_decode: assert property (st.use_pins && pins == adcpp_pkg::PINS_SLEEP |-> sleep_now && !mux_now)
		else $error("sleep pin code not decoded");
endmodule // adcpp_top

`default_nettype wire

/* shared/adcpp_pkg.sv */
// Shared constants and types for the converter post-processing block
package adcpp_pkg;
	localparam int SAMPLE_W = 14;
	localparam int LAT_RAW = 16;
	localparam int LAT_EXTRA = 4;
	localparam int LAT_DIG = LAT_RAW + LAT_EXTRA;
	localparam int ACC_W = 47;
	localparam int TC_BASE_SHIFT = 20;
	localparam logic [3:0] TC_MAX_CODE = 4'h000b;
	localparam logic [3:0] GAIN_MAX_CODE = 4'h000c;
	localparam int GAIN_FRAC = 12;
	localparam int FULL_SCALE_MV = 2000;
	localparam int OFFSET_MAX_MV = 10;
	localparam int OFFSET_LIMIT_LSB = OFFSET_MAX_MV * (2 ** SAMPLE_W) / FULL_SCALE_MV;
	localparam int CLK_PERIOD_PS = 4000;
	localparam int SLEEP_WAKE_US = 100;
	localparam int STANDBY_WAKE_US = 50;
	localparam int SLEEP_WAKE_CYCLES = SLEEP_WAKE_US * 1000000 / CLK_PERIOD_PS;
	localparam int STANDBY_WAKE_CYCLES = STANDBY_WAKE_US * 1000000 / CLK_PERIOD_PS;
	localparam int WAKE_W = 15;
	// Register offsets (byte addresses)
	localparam logic [7:0] REG_CONTROL = 8'h0000;
	localparam logic [7:0] REG_POWER = 8'h0004;
	localparam logic [7:0] REG_STATUS = 8'h0008;
	localparam logic [7:0] REG_OFFSET_A = 8'h000c;
	localparam logic [7:0] REG_OFFSET_B = 8'h0010;
	// CONTROL fields
	localparam int CTL_DIG_EN = 0;
	localparam int CTL_OFF_EN = 1;
	localparam int CTL_OFF_HOLD = 2;
	localparam int CTL_GAIN_LO = 4;
	localparam int CTL_TC_LO = 8;
	localparam logic CTL_OFF_HOLD_RST = 1'h1;
	// POWER fields
	localparam int PWR_SLEEP = 0;
	localparam int PWR_STBY_A = 1;
	localparam int PWR_STBY_B = 2;
	localparam int PWR_MUX = 3;
	localparam int PWR_USE_PINS = 4;
	// STATUS fields
	localparam int STS_SLEEP = 0;
	localparam int STS_VALID_A = 1;
	localparam int STS_VALID_B = 2;
	localparam int STS_PIN_BAD = 3;
	localparam int STS_FS_LO = 8;
	// Control pin codes, {pin_3, pin_2, pin_1}
	localparam logic [2:0] PINS_NORMAL = 3'h0;
	localparam logic [2:0] PINS_SLEEP = 3'h1;
	localparam logic [2:0] PINS_A_DOWN = 3'h5;
	localparam logic [2:0] PINS_MUX = 3'h7;

	typedef enum logic [1:0] {
		ADCPP_PM_NORMAL = 2'b00,
		ADCPP_PM_SLEEP = 2'b01,
		ADCPP_PM_A_DOWN = 2'b10,
		ADCPP_PM_MUX = 2'b11
	} adcpp_pm_e;
endpackage

/* testbench/adcpp_rx_model.sv */
// Receiver model that captures converter output samples
`timescale 1ns/1ps
`default_nettype none
module adcpp_rx_model (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [13:0] bus_a_i,
	input wire logic [13:0] bus_b_i,
	input wire logic oe_a_i,
	input wire logic oe_b_i,
	input wire logic valid_a_i,
	input wire logic valid_b_i,
	input wire logic mux_a_i,
	output logic [13:0] rx_a_o,
	output logic [7:0] n_mux_a_o
);
	// Samples seen while not valid are dropped, never captured
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_a_o <= 14'h0000;
			n_mux_a_o <= 8'h00;
		end else if (oe_a_i && valid_a_i) begin
			rx_a_o <= bus_a_i;
		end else if (oe_b_i && valid_b_i && mux_a_i) begin
			rx_a_o <= bus_b_i;
			n_mux_a_o <= n_mux_a_o + 8'h01;
		end
	end
endmodule // adcpp_rx_model
`default_nettype wire

/* testbench/test_adc_post_processing_and_power_modes.sv */
// Self-checking testbench of the converter post-processing block
`timescale 1ns/1ps
`default_nettype none
module test_adc_post_processing_and_power_modes;
	logic clk_i, rst_n_i, reg_wr_i, reg_rd_i, const_on;
	logic [13:0] sample_a_i, sample_b_i, const_v, va, vb, bus_a, bus_b;
	logic [2:0] pins;
	logic [7:0] reg_addr_i, n_mux_a;
	logic [7:0] cyc = 8'h00;
	logic [31:0] reg_wdata_i, reg_rdata_o, d, e1;
	logic oe_a, oe_b, val_a, val_b, mux_a;
	logic [13:0] ha [256];
	logic [13:0] hb [256];
	int n_errors, total_checks, n;
	adcpp_top #(.SLEEP_WAKE(15'h0014), .STANDBY_WAKE(15'h000c)) adcpp_top_inst (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .sample_a_i(sample_a_i), .sample_b_i(sample_b_i),
		.power_mode_pin_1_i(pins[0]), .power_mode_pin_2_i(pins[1]), .power_mode_pin_3_i(pins[2]),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .channel_a_output_bus_o(bus_a), .channel_a_output_oe_o(oe_a),
		.channel_b_output_bus_o(bus_b), .channel_b_output_oe_o(oe_b), .channel_a_valid_o(val_a),
		.channel_b_valid_o(val_b), .mux_carries_a_o(mux_a));
	adcpp_rx_model adcpp_rx_model_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus_a_i(bus_a),
		.bus_b_i(bus_b), .oe_a_i(oe_a), .oe_b_i(oe_b), .valid_a_i(val_a), .valid_b_i(val_b),
		.mux_a_i(mux_a), .rx_a_o(), .n_mux_a_o(n_mux_a));
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	// History of what each channel was given, indexed by edge count
	always @(posedge clk_i) begin
		va = const_on ? const_v : 14'($urandom);
		vb = const_on ? const_v : 14'($urandom);
		sample_a_i <= va;
		sample_b_i <= vb;
		ha[cyc] <= va;
		hb[cyc] <= vb;
		cyc <= cyc + 8'h01;
	end
	task automatic stop_test();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= v;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		@(negedge clk_i);
		v = reg_rdata_o;
	endtask
	task automatic lat_chk(input int lat);
		repeat (40) begin
			@(negedge clk_i);
			check("bus_a", bus_a, ha[8'(cyc - 1 - lat)]);
			check("bus_b", bus_b, hb[8'(cyc - 1 - lat)]);
		end
	endtask
	// Bounded wait for a channel to report valid again
	task automatic wake(input logic b, output int w);
		w = 0;
		while ((b ? val_b : val_a) !== 1'b1 && w < 200) begin
			@(negedge clk_i);
			w++;
		end
		if (w >= 200) begin
			n_errors++;
			stop_test();
		end
	endtask
	function automatic logic [31:0] ctl(input logic dg, of, hd, input logic [3:0] g, tc);
		return {20'h0_0000, tc, g, 1'b0, hd, of, dg};
	endfunction
	function automatic logic [11:0] fs_mv(input int i);
		logic [11:0] t [7] = '{12'h07d0, 12'h06f4, 12'h0636, 12'h058c, 12'h04ec, 12'h0460, 12'h03e8};
		return t[i];
	endfunction
	initial begin
		void'($urandom(32'h9e08));
		{rst_n_i, reg_wr_i, reg_rd_i, const_on, pins} = '0;
		{reg_addr_i, reg_wdata_i, const_v} = '0;
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rd(adcpp_pkg::REG_CONTROL, d);
		check("control", d, 32'h0000_0004);
		rd(adcpp_pkg::REG_POWER, d);
		check("power", d, 32'h0000_0000);
		rd(8'h0044, d);
		check("unmapped", d, 32'h0000_0000);
		rd(adcpp_pkg::REG_STATUS, d);
		check("fs_reset", d[19:8], 12'h07d0);
		repeat (30) @(posedge clk_i);
		lat_chk(16);
		wr(adcpp_pkg::REG_CONTROL, ctl(0, 0, 1, 4'hc, 4'h0));
		lat_chk(16);
		wr(adcpp_pkg::REG_CONTROL, ctl(1, 0, 1, 4'h0, 4'h0));
		repeat (30) @(posedge clk_i);
		lat_chk(adcpp_pkg::LAT_DIG);
		for (int i = 0; i < 7; i++) begin
			wr(adcpp_pkg::REG_CONTROL, ctl(1, 0, 1, 4'(2 * i), 4'h0));
			rd(adcpp_pkg::REG_STATUS, d);
			check("full_scale", d[19:8], fs_mv(i));
		end
		for (int i = 0; i < 16; i++) begin
			wr(adcpp_pkg::REG_CONTROL, ctl(1, 0, 1, 4'(i), 4'(i)));
			rd(adcpp_pkg::REG_CONTROL, d);
			check("gain_code", d[7:4], (i > 12) ? 12 : i);
			check("tc_code", d[11:8], (i > 11) ? 11 : i);
		end
		// Large constant offset so the slowest-free loop moves within the run
		const_v <= 14'h03e8;
		const_on <= 1'b1;
		wr(adcpp_pkg::REG_CONTROL, ctl(1, 1, 1, 4'h0, 4'h0));
		repeat (6000) @(posedge clk_i);
		wr(adcpp_pkg::REG_CONTROL, ctl(1, 1, 0, 4'h0, 4'h0));
		rd(adcpp_pkg::REG_OFFSET_A, e1);
		check("est_range", $signed(e1) > 0 && $signed(e1) <= 81, 1);
		// Long enough for a running loop to move its estimate
		repeat (2000) @(posedge clk_i);
		rd(adcpp_pkg::REG_OFFSET_A, d);
		check("est_held", d, e1);
		check("corrected", bus_a, 14'(14'h03e8 - e1[13:0]));
		wr(adcpp_pkg::REG_CONTROL, ctl(1, 0, 1, 4'h0, 4'h0));
		repeat (30) @(negedge clk_i);
		check("uncorrected", bus_a, 14'h03e8);
		const_on <= 1'b0;
		wr(adcpp_pkg::REG_POWER, 32'h0000_0001);
		repeat (30) @(negedge clk_i);
		check("sleep_oe", {oe_a, oe_b}, 2'h0);
		rd(adcpp_pkg::REG_STATUS, d);
		check("sleep_sts", d[0], 1'b1);
		wr(adcpp_pkg::REG_POWER, 32'h0000_0000);
		wake(1'b1, n);
		check("sleep_wake", n >= 16 && n <= 25, 1);
		wr(adcpp_pkg::REG_POWER, 32'h0000_0002);
		repeat (30) @(negedge clk_i);
		check("stby_bus", bus_a, 14'h0000);
		wr(adcpp_pkg::REG_POWER, 32'h0000_0000);
		wake(1'b0, n);
		check("stby_wake", n >= 8 && n <= 17, 1);
		wr(adcpp_pkg::REG_POWER, 32'h0000_0010);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_i);
			pins <= (i == 0) ? 3'h0 : (i == 1) ? 3'h1 : (i == 2) ? 3'h5 : 3'h7;
			repeat (30) @(negedge clk_i);
			check("pin_oe", {oe_a, oe_b}, (i == 1) ? 2'h0 : (i == 3) ? 2'h1 : 2'h3);
			if (i == 2)
				check("pin_a_down", bus_a, 14'h0000);
			if (i == 3)
				check("mux_bus_b", bus_b, mux_a ? ha[8'(cyc - 21)] : hb[8'(cyc - 21)]);
		end
		check("mux_a_seen", n_mux_a >= 8'h04, 1);
		rd(adcpp_pkg::REG_STATUS, d);
		check("pin_ok", d[3], 1'b0);
		@(posedge clk_i);
		pins <= 3'h0;
		stop_test();
	end
endmodule // test_adc_post_processing_and_power_modes
`default_nettype wire
